// >>> rtl/cfg_snoop_pkg.sv
package cfg_snoop_pkg;

  // Configuration space offsets of the extension registers
  localparam logic [7:0]  ACCESS_CONTROL_OFS = 8'h40;
  localparam logic [7:0]  SNOOP_ZERO_OFS     = 8'h44;
  localparam logic [7:0]  SNOOP_ONE_OFS      = 8'h48;
  localparam logic [7:0]  STATUS_ALIAS_OFS   = 8'h4C;

  // Field positions in access_control
  localparam int          INIT_WE_BIT    = 0;
  localparam int          FIFO_WE_BIT    = 1;
  localparam int          REMAP_BIT      = 2;
  localparam int          SNP0_EN_BIT    = 4;
  localparam int          SNP0_IO_BIT    = 5;
  localparam int          SNP0_RD_BIT    = 6;
  localparam int          SNP1_EN_BIT    = 7;
  localparam int          SNP1_IO_BIT    = 8;
  localparam int          SNP1_RD_BIT    = 9;
  localparam int          OWNER_BIT      = 10;
  localparam int          ROLE_BIT       = 11;

  // Interleave enable position in init_register_one
  localparam int          INTERLEAVE_EN_BIT = 23;

  // Implemented bits of access_control; bit 3 and 31:12 read zero
  localparam logic [31:0] ACCESS_CONTROL_MASK  = 32'h00000FF7;
  localparam logic [31:0] ACCESS_CONTROL_RESET = 32'h00000000;
  localparam logic [31:0] SNOOP_RESET          = 32'h00000000;
  localparam logic [31:0] READ_ZERO            = 32'h00000000;

  // Memory matching ignores address bits 1:0
  localparam logic [31:0] MEM_ADDR_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] IO_ADDR_MASK  = 32'hFFFFFFFF;

  // Initialisation register indices that may be remapped
  localparam logic [1:0]  INIT_INDEX_TWO   = 2'h2;
  localparam logic [1:0]  INIT_INDEX_THREE = 2'h3;

endpackage

// >>> rtl/snoop_comparator.sv
`timescale 1ns/1ns
module snoop_comparator
  import cfg_snoop_pkg::*;
(
  input  wire logic        enable_i,
  input  wire logic        match_io_i,
  input  wire logic        match_read_i,
  input  wire logic [31:0] snoop_addr_i,
  input  wire logic        cycle_valid_i,
  input  wire logic        cycle_is_io_i,
  input  wire logic        cycle_is_read_i,
  input  wire logic [31:0] cycle_addr_i,
  output logic             match_o
);

  logic [31:0] addr_mask;

  // Low address bits only count for I/O matching
  always_comb begin
    addr_mask = match_io_i ? IO_ADDR_MASK : MEM_ADDR_MASK;
    match_o   = enable_i && cycle_valid_i
              && (cycle_is_io_i == match_io_i)
              && (cycle_is_read_i == match_read_i)
              && ((cycle_addr_i & addr_mask)
                  == (snoop_addr_i & addr_mask));
  end

endmodule

// >>> rtl/pci_config_snoop_control.sv
`timescale 1ns/1ns
// Summary of operation
// - Bit 0 enables init register writes
// - Init writes dropped while bit 0 clear
// - Bit 1 enables host command FIFO writes
// - Bit 2 remaps init two, three
// - Bits 4-6 configure snoop comparator zero
// - Bits 7-9 configure snoop comparator one
// - Bit 10 picks interleave bus owner
// - Bit 11 sets own interleave role
// - Interleaved, drive bus when bits match
// - Matching snooped cycle sets passthrough pin
// - Snoop match never claims the cycle
// - Address 1:0 compared for I/O only
// - Snoop address registers read as zero
// - Status alias returns live status word
module pci_config_snoop_control
  import cfg_snoop_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        cfg_write_i,
  input  wire logic        cfg_read_i,
  input  wire logic [7:0]  cfg_addr_i,
  input  wire logic [31:0] cfg_wdata_i,
  output logic [31:0]      cfg_rdata_o,
  output logic             cfg_rvalid_o,
  input  wire logic [31:0] status_word_i,
  input  wire logic [31:0] init_register_one_i,
  input  wire logic        init_access_i,
  input  wire logic        init_is_write_i,
  input  wire logic [1:0]  init_index_i,
  input  wire logic [31:0] init_wdata_i,
  output logic             init_write_o,
  output logic [1:0]       init_index_o,
  output logic [31:0]      init_wdata_o,
  output logic             remap_access_o,
  output logic             remap_sel_o,
  input  wire logic        fifo_push_i,
  output logic             fifo_push_o,
  output logic             fifo_write_enable_o,
  output logic             interleave_role_o,
  output logic             bus_drive_enable_o,
  input  wire logic        cycle_valid_i,
  input  wire logic        cycle_is_io_i,
  input  wire logic        cycle_is_read_i,
  input  wire logic [31:0] cycle_addr_i,
  output logic             pass_select_o
);

  logic [31:0] access_control;
  logic [31:0] snoop_address_zero;
  logic [31:0] snoop_address_one;
  logic [31:0] next_access_control;
  logic [31:0] next_snoop_address_zero;
  logic [31:0] next_snoop_address_one;
  logic [31:0] next_cfg_rdata;
  logic        next_cfg_rvalid;
  logic        next_init_write;
  logic [1:0]  next_init_index;
  logic [31:0] next_init_wdata;
  logic        next_remap_access;
  logic        next_remap_sel;
  logic        next_fifo_push;
  logic        next_bus_drive;
  logic        next_pass_select;
  logic        match_zero;
  logic        match_one;
  logic        remap_hit;

  // Snoop comparators only observe; nothing answers the cycle
  snoop_comparator u_snoop_zero (
    .enable_i        (access_control[SNP0_EN_BIT]),
    .match_io_i      (access_control[SNP0_IO_BIT]),
    .match_read_i    (access_control[SNP0_RD_BIT]),
    .snoop_addr_i    (snoop_address_zero),
    .cycle_valid_i   (cycle_valid_i),
    .cycle_is_io_i   (cycle_is_io_i),
    .cycle_is_read_i (cycle_is_read_i),
    .cycle_addr_i    (cycle_addr_i),
    .match_o         (match_zero)
  );

  snoop_comparator u_snoop_one (
    .enable_i        (access_control[SNP1_EN_BIT]),
    .match_io_i      (access_control[SNP1_IO_BIT]),
    .match_read_i    (access_control[SNP1_RD_BIT]),
    .snoop_addr_i    (snoop_address_one),
    .cycle_valid_i   (cycle_valid_i),
    .cycle_is_io_i   (cycle_is_io_i),
    .cycle_is_read_i (cycle_is_read_i),
    .cycle_addr_i    (cycle_addr_i),
    .match_o         (match_one)
  );

  // Configuration register writes and reads
  always_comb begin
    next_access_control     = access_control;
    next_snoop_address_zero = snoop_address_zero;
    next_snoop_address_one  = snoop_address_one;
    next_cfg_rvalid         = cfg_read_i;
    next_cfg_rdata          = READ_ZERO;
    if (cfg_write_i) begin
      case (cfg_addr_i)
        ACCESS_CONTROL_OFS: begin
          next_access_control = cfg_wdata_i & ACCESS_CONTROL_MASK;
        end
        SNOOP_ZERO_OFS:     next_snoop_address_zero = cfg_wdata_i;
        SNOOP_ONE_OFS:      next_snoop_address_one  = cfg_wdata_i;
        default:            ;
      endcase
    end
    if (cfg_read_i) begin
      case (cfg_addr_i)
        ACCESS_CONTROL_OFS: next_cfg_rdata = access_control;
        SNOOP_ZERO_OFS:     next_cfg_rdata = READ_ZERO;
        SNOOP_ONE_OFS:      next_cfg_rdata = READ_ZERO;
        STATUS_ALIAS_OFS:   next_cfg_rdata = status_word_i;
        default:            next_cfg_rdata = READ_ZERO;
      endcase
    end
  end

  // Register file state
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      access_control     <= ACCESS_CONTROL_RESET;
      snoop_address_zero <= SNOOP_RESET;
      snoop_address_one  <= SNOOP_RESET;
      cfg_rdata_o        <= READ_ZERO;
      cfg_rvalid_o       <= 1'b0;
    end else begin
      access_control     <= next_access_control;
      snoop_address_zero <= next_snoop_address_zero;
      snoop_address_one  <= next_snoop_address_one;
      cfg_rdata_o        <= next_cfg_rdata;
      cfg_rvalid_o       <= next_cfg_rvalid;
    end
  end

  // Init register gating, remap steering and FIFO gating
  always_comb begin
    remap_hit = access_control[REMAP_BIT]
              && (init_index_i == INIT_INDEX_TWO
                  || init_index_i == INIT_INDEX_THREE);
    next_remap_access = init_access_i && remap_hit;
    next_remap_sel    = (init_index_i == INIT_INDEX_THREE);
    next_init_write   = init_access_i && init_is_write_i && !remap_hit
                      && access_control[INIT_WE_BIT];
    next_init_index   = init_index_i;
    next_init_wdata   = init_wdata_i;
    next_fifo_push    = fifo_push_i
                      && access_control[FIFO_WE_BIT];
    // Interleaved, drive only when owner choice equals own role; always drive otherwise
    next_bus_drive    = !init_register_one_i[INTERLEAVE_EN_BIT]
                      || (access_control[ROLE_BIT]
                          == access_control[OWNER_BIT]);
    // Passthrough select is sticky until reset
    next_pass_select  = pass_select_o || match_zero
                      || match_one;
  end

  // Output stage; snoop result touches no bus response
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      init_write_o        <= 1'b0;
      init_index_o        <= 2'h0;
      init_wdata_o        <= 32'h00000000;
      remap_access_o      <= 1'b0;
      remap_sel_o         <= 1'b0;
      fifo_push_o         <= 1'b0;
      fifo_write_enable_o <= 1'b0;
      interleave_role_o   <= 1'b0;
      bus_drive_enable_o  <= 1'b1;
      pass_select_o       <= 1'b0;
    end else begin
      init_write_o        <= next_init_write;
      init_index_o        <= next_init_index;
      init_wdata_o        <= next_init_wdata;
      remap_access_o      <= next_remap_access;
      remap_sel_o         <= next_remap_sel;
      fifo_push_o         <= next_fifo_push;
      fifo_write_enable_o <= access_control[FIFO_WE_BIT];
      interleave_role_o   <= access_control[ROLE_BIT];
      bus_drive_enable_o  <= next_bus_drive;
      pass_select_o       <= next_pass_select;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_init_write_gate: assert property (
    init_write_o |-> $past(access_control[INIT_WE_BIT])
                     && $past(init_is_write_i)
  ) else $error("init write passed while disabled");

  a_init_write_pass: assert property (
    init_access_i && init_is_write_i && access_control[INIT_WE_BIT]
    && !access_control[REMAP_BIT] |=> init_write_o
  ) else $error("enabled init write dropped");

  a_fifo_push_gate: assert property (
    fifo_push_o |-> $past(access_control[FIFO_WE_BIT])
  ) else $error("fifo push passed while disabled");

  a_remap_steer: assert property (
    init_access_i && access_control[REMAP_BIT]
    && init_index_i == INIT_INDEX_THREE
    |=> remap_access_o && remap_sel_o && !init_write_o
  ) else $error("remapped access not steered");

  a_snoop_read_zero: assert property (
    cfg_read_i && (cfg_addr_i == SNOOP_ZERO_OFS
                   || cfg_addr_i == SNOOP_ONE_OFS)
    |=> cfg_rvalid_o && cfg_rdata_o == READ_ZERO
  ) else $error("snoop address read not zero");

  a_status_alias: assert property (
    cfg_read_i && cfg_addr_i == STATUS_ALIAS_OFS
    |=> cfg_rdata_o == $past(status_word_i)
  ) else $error("status alias mismatch");

  a_snoop_sets_pin: assert property (
    match_zero || match_one |=> pass_select_o [*2]
  ) else $error("snoop match did not set pin");

  a_pin_needs_match: assert property (
    $rose(pass_select_o) |-> $past(match_zero || match_one)
  ) else $error("pin set without a match");

  a_bus_drive_rule: assert property (
    init_register_one_i[INTERLEAVE_EN_BIT]
    && access_control[ROLE_BIT] != access_control[OWNER_BIT]
    |=> !bus_drive_enable_o
  ) else $error("bus driven by wrong interleave role");

  a_role_follows: assert property (
    cfg_write_i && cfg_addr_i == ACCESS_CONTROL_OFS
    |=> ##1 interleave_role_o == $past(cfg_wdata_i[ROLE_BIT], 2)
  ) else $error("interleave role not updated");

endmodule

// >>> verif/host_cfg_model.sv
`timescale 1ns/1ns
module host_cfg_model (
  input  wire logic        clk_i,
  output logic             cfg_write_o,
  output logic             cfg_read_o,
  output logic [7:0]       cfg_addr_o,
  output logic [31:0]      cfg_wdata_o
);
  // Host starts idle
  initial begin
    cfg_write_o = 1'b0;
    cfg_read_o  = 1'b0;
    cfg_addr_o  = 8'h00;
    cfg_wdata_o = 32'h00000000;
  end

  // One-cycle write; software enables FIFO writes this way
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cfg_write_o <= 1'b1;
    cfg_addr_o  <= a;
    cfg_wdata_o <= d;
    @(posedge clk_i);
    cfg_write_o <= 1'b0;
    cfg_wdata_o <= ~d;
  endtask

  // One-cycle read; caller samples the answer just after return
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    cfg_read_o <= 1'b1;
    cfg_addr_o <= a;
    @(posedge clk_i);
    cfg_read_o <= 1'b0;
    #1;
  endtask
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ns
module testbench;
  import cfg_snoop_pkg::*;
  logic        clk_i, reset_n_i, cfg_write_i, cfg_read_i, cfg_rvalid_o;
  logic        init_access_i, init_is_write_i, init_write_o, fifo_push_i;
  logic        remap_access_o, remap_sel_o, fifo_push_o, fifo_write_enable_o;
  logic        interleave_role_o, bus_drive_enable_o, cycle_valid_i;
  logic        cycle_is_io_i, cycle_is_read_i, pass_select_o;
  logic [1:0]  init_index_i, init_index_o;
  logic [7:0]  cfg_addr_i;
  logic [31:0] cfg_wdata_i, cfg_rdata_o, status_word_i, init_register_one_i;
  logic [31:0] init_wdata_i, init_wdata_o, cycle_addr_i;
  int          failures, tests_run;

  // Register rows: offset, write data, expected read back
  localparam logic [71:0] ROWS [6] = '{
    {ACCESS_CONTROL_OFS, 32'hFFFFFFFF, 32'h00000FF7},
    {SNOOP_ZERO_OFS, 32'h12345678, 32'h00000000},
    {SNOOP_ONE_OFS, 32'hFFFFFFFF, 32'h00000000},
    {8'h50, 32'hFFFFFFFF, 32'h00000000},
    {STATUS_ALIAS_OFS, 32'h00000000, 32'hA5A50F0F},
    {ACCESS_CONTROL_OFS, 32'h00000000, 32'h00000000}};

  pci_config_snoop_control i_dut (.*);
  host_cfg_model i_host (.clk_i(clk_i), .cfg_write_o(cfg_write_i),
    .cfg_read_o(cfg_read_i), .cfg_addr_o(cfg_addr_i),
    .cfg_wdata_o(cfg_wdata_i));

  // Free-running 20 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Compare one value and count it
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Print counts and verdict, then stop
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hold reset for 16 cycles
  task automatic rst();
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    @(posedge clk_i);
    #1;
  endtask

  // Pulse the chosen strobes {cycle, fifo, init} for one cycle
  task automatic go(input logic [2:0] m);
    @(posedge clk_i);
    {cycle_valid_i, fifo_push_i, init_access_i} <= m;
    @(posedge clk_i);
    {cycle_valid_i, fifo_push_i, init_access_i} <= 3'h0;
    #1;
  endtask

  // Write access_control and let level outputs follow
  task automatic ac(input logic [31:0] d);
    i_host.wr(ACCESS_CONTROL_OFS, d);
    @(posedge clk_i);
    #1;
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    summarize();
  end

  // Main sequence
  initial begin
    failures = 0;
    tests_run = 0;
    reset_n_i = 1'b0;
    {init_access_i, init_is_write_i, fifo_push_i, cycle_valid_i} = 4'h0;
    {cycle_is_io_i, cycle_is_read_i, init_index_i} = 4'h0;
    init_wdata_i = 32'h00000000;
    cycle_addr_i = 32'h00000000;
    status_word_i = 32'hA5A50F0F;
    init_register_one_i = 32'h00000000;
    rst();
    i_host.rd(ACCESS_CONTROL_OFS);
    chk("reset value", ACCESS_CONTROL_RESET, cfg_rdata_o);
    chk("read valid", 32'h1, 32'(cfg_rvalid_o));
    chk("reset drive", 32'h1, 32'(bus_drive_enable_o));
    $display("test reset done");
    foreach (ROWS[i]) begin
      i_host.wr(ROWS[i][71:64], ROWS[i][63:32]);
      i_host.rd(ROWS[i][71:64]);
      chk("cfg read", ROWS[i][31:0], cfg_rdata_o);
    end
    @(posedge clk_i);
    status_word_i <= 32'h5A5AF0F0;
    i_host.rd(STATUS_ALIAS_OFS);
    chk("status live", 32'h5A5AF0F0, cfg_rdata_o);
    $display("test registers done");
    @(posedge clk_i);
    init_is_write_i <= 1'b1;
    init_index_i <= 2'h1;
    init_wdata_i <= 32'hC0DE1234;
    go(3'h1);
    chk("blocked init", 32'h0, 32'(init_write_o));
    ac(32'h1);
    go(3'h1);
    chk("init strobe", 32'h5, {29'h0, init_write_o, init_index_o});
    chk("init data", 32'hC0DE1234, init_wdata_o);
    ac(32'h5);
    @(posedge clk_i);
    init_is_write_i <= 1'b0;
    init_index_i <= INIT_INDEX_TWO;
    go(3'h1);
    chk("remap two", 32'h4, {29'h0, remap_access_o, remap_sel_o,
      init_write_o});
    @(posedge clk_i);
    init_is_write_i <= 1'b1;
    init_index_i <= INIT_INDEX_THREE;
    go(3'h1);
    chk("remap three", 32'h6, {29'h0, remap_access_o, remap_sel_o,
      init_write_o});
    $display("test init done");
    go(3'h2);
    chk("fifo blocked", 32'h0, {30'h0, fifo_write_enable_o,
      fifo_push_o});
    ac(32'h2);
    go(3'h2);
    chk("fifo push", 32'h3, {30'h0, fifo_write_enable_o,
      fifo_push_o});
    @(posedge clk_i);
    init_register_one_i <= 32'h00800000;
    for (int k = 0; k < 4; k++) begin
      ac(32'(k) << 10);
      chk("interleave", {30'h0, k[1], k[1] == k[0]}, {30'h0,
        interleave_role_o, bus_drive_enable_o});
    end
    @(posedge clk_i);
    init_register_one_i <= 32'h00000000;
    ac(32'h400);
    chk("no interleave", 32'h1, 32'(bus_drive_enable_o));
    $display("test interleave done");
    i_host.wr(SNOOP_ZERO_OFS, 32'h00001003);
    ac(32'h10);
    @(posedge clk_i);
    cycle_addr_i <= 32'h00001000;
    cycle_is_read_i <= 1'b1;
    go(3'h4);
    chk("snoop direction", 32'h0, 32'(pass_select_o));
    @(posedge clk_i);
    cycle_is_read_i <= 1'b0;
    go(3'h4);
    chk("snoop memory", 32'h1, 32'(pass_select_o));
    rst();
    chk("snoop cleared", 32'h0, 32'(pass_select_o));
    i_host.wr(SNOOP_ONE_OFS, 32'h00002002);
    ac(32'h380);
    @(posedge clk_i);
    {cycle_is_io_i, cycle_is_read_i} <= 2'h3;
    cycle_addr_i <= 32'h00002003;
    go(3'h4);
    chk("snoop io low bits", 32'h0, 32'(pass_select_o));
    @(posedge clk_i);
    cycle_addr_i <= 32'h00002002;
    go(3'h4);
    chk("snoop io", 32'h1, 32'(pass_select_o));
    $display("test snoop done");
    summarize();
  end
endmodule
